// ==== hdl/cfpl_pkg.sv ====
// package: constants and carriers for converter fault protection logic
package cfpl_pkg;
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned OPP_TIME_MS     = 160;
   localparam int unsigned FDR_TIME_MS     = 1500;
   localparam int unsigned OPP_CYCLES      = CLK_HZ / 1000 * OPP_TIME_MS;
   localparam int unsigned FDR_CYCLES      = CLK_HZ / 1000 * FDR_TIME_MS;
   localparam int unsigned CNT_W           = 28;
   localparam logic [1:0]  QUAL_PULSES     = 2'h3;
   localparam logic [1:0]  TEST_PULSES_MIN = 2'h3;
   localparam logic [27:0] CNT_RESET       = 28'h0000000;

   typedef enum logic [1:0]
   {
      CFPL_RUN      = 2'b00,
      CFPL_RECOVER  = 2'b01,
      CFPL_WAIT_OFF = 2'b10
   } cfpl_state_t;

   // comparator results, raw from the pins; cfpl_top synchronises them through cfpl_sync
   typedef struct packed
   {
      logic ntc_low;
      logic cst_over_opp;
      logic cs_over_ocp;
      logic vs_below_short;
   } cfpl_cmp_t;

   typedef struct packed
   {
      logic gate_inhibit;
      logic run;
      logic ntc_ref_high;
      logic recovery_active;
      logic otp_fault;
      logic opp_fault;
      logic ocp_fault;
      logic scp_fault;
   } cfpl_stat_t;
endpackage

// ==== hdl/cfpl_sync.sv ====
// three-stage synchroniser with second/third agreement filter
`timescale 1ns/10ps
module cfpl_sync
#(
   parameter int unsigned W = 4
)
(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } cfpl_sync_st_t;

   cfpl_sync_st_t st_q;
   cfpl_sync_st_t st_d;

   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < W; i++)
      begin
         if (st_q.s2[i] == st_q.s3[i])
         begin
            st_d.out[i] = st_q.s3[i];
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.out;
endmodule

// ==== hdl/cfpl_top.sv ====
// fault protection sequencer for an active-clamp flyback controller
`timescale 1ns/10ps
// Summary of operation
// RULE1: thermistor low over three pulses latches over-temperature; the code latches on the fourth such pulse
// RULE2: 1 V reference, source on while no fault
// RULE3: latched fault raises reference to 2.25 V
// RULE4: fault clears only above raised reference
// RULE5: external shutdown keeps lockout cycling, test pulses
// RULE6: over-power threshold exceeded starts 160 ms timer
// RULE7: 160 ms continuous over-power stops switching, recovers
// RULE8: timer clears when below threshold before expiry
// RULE9: over-power threshold top is 0.6 V
// RULE10: peak current clamped at 0.8 V always
// RULE11: at turn-off, short condition starts recovery
// RULE12: 1.2 V over-current three cycles stops, recovers
// RULE13: recovery keeps lockout cycling, no test pulses
// RULE14: after recovery, restart at next turn-off
// RULE15: counters reset on any non-qualifying pulse
module cfpl_top
#(
   parameter int unsigned OPP_CYCLES_P = cfpl_pkg::OPP_CYCLES,
   parameter int unsigned FDR_CYCLES_P = cfpl_pkg::FDR_CYCLES
)
(
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire cfpl_pkg::cfpl_cmp_t cmp_pins,
   input  wire logic                low_side_gate_pulse,
   input  wire logic                supply_turn_off,
   output cfpl_pkg::cfpl_stat_t     status,
   output logic                     ntc_source_en,
   output logic                     peak_current_clamp,
   output logic                     test_pulse_allow
);
   import cfpl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed
   {
      cfpl_state_t state;
      logic [1:0]  otp_cnt;
      logic [1:0]  ocp_cnt;
      logic [1:0]  test_cnt;
      logic [27:0] opp_cnt;
      logic [27:0] fdr_cnt;
      logic        otp_fault;
      logic        opp_fault;
      logic        ocp_fault;
      logic        scp_fault;
      logic        pulse_q;
      logic        off_q;
      cfpl_stat_t  stat;
      logic        ntc_src;
      logic        clamp;
      logic        test_ok;
   } cfpl_st_t;

   cfpl_st_t  st_q;
   cfpl_st_t  st_d;
   cfpl_cmp_t cmp_s;
   logic      pulse_s;
   logic      off_s;
   logic      pulse_evt;
   logic      off_evt;
   logic      enter_fdr;

   // pins are analog comparator outputs, so all go through the filter
   cfpl_sync #(.W(6)) cfpl_sync_i
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     ({cmp_pins, low_side_gate_pulse, supply_turn_off}),
      .dout    ({cmp_s, pulse_s, off_s})
   );

   assign pulse_evt = pulse_s & ~st_q.pulse_q;
   assign off_evt   = off_s & ~st_q.off_q;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_d         = st_q;
      st_d.pulse_q = pulse_s;
      st_d.off_q   = off_s;
      enter_fdr    = 1'b0;

      // comparator tracks whichever reference is selected
      if (pulse_evt)
      begin
         if (!st_q.otp_fault)
         begin
            if (cmp_s.ntc_low)
            begin
               if (st_q.otp_cnt == QUAL_PULSES) // RULE1
               begin
                  st_d.otp_fault = 1'b1; // RULE3
                  st_d.otp_cnt   = '0;
               end
               else
               begin
                  st_d.otp_cnt = st_q.otp_cnt + 2'h1;
               end
            end
            else
            begin
               st_d.otp_cnt = '0; // RULE15
            end
         end
         else if (!cmp_s.ntc_low)
         begin
            st_d.otp_fault = 1'b0; // RULE4
         end
         if (st_q.test_cnt != TEST_PULSES_MIN)
         begin
            st_d.test_cnt = st_q.test_cnt + 2'h1; // RULE5
         end
      end

      if (st_q.state == CFPL_RUN)
      begin
         if (cmp_s.cst_over_opp) // RULE9
         begin
            if (st_q.opp_cnt >= CNT_W'(OPP_CYCLES_P - 1)) // RULE7
            begin
               st_d.opp_fault = 1'b1;
               enter_fdr      = 1'b1;
            end
            else
            begin
               st_d.opp_cnt = st_q.opp_cnt + 28'h0000001; // RULE6
            end
         end
         else
         begin
            st_d.opp_cnt = CNT_RESET; // RULE8
         end

         if (pulse_evt)
         begin
            if (cmp_s.cs_over_ocp)
            begin
               if (st_q.ocp_cnt == QUAL_PULSES - 2'h1) // RULE12
               begin
                  st_d.ocp_fault = 1'b1;
                  enter_fdr      = 1'b1;
               end
               else
               begin
                  st_d.ocp_cnt = st_q.ocp_cnt + 2'h1;
               end
            end
            else
            begin
               st_d.ocp_cnt = '0; // RULE15
            end
         end

         if (off_evt)
         begin
            st_d.test_cnt = '0; // RULE5
            if (cmp_s.cst_over_opp || cmp_s.vs_below_short) // RULE11
            begin
               st_d.scp_fault = 1'b1;
               enter_fdr      = 1'b1;
            end
         end
      end

      case (st_q.state)
         CFPL_RUN:
         begin
            if (enter_fdr)
            begin
               st_d.state   = CFPL_RECOVER;
               st_d.fdr_cnt = CNT_RESET;
               st_d.opp_cnt = CNT_RESET;
               st_d.ocp_cnt = '0;
            end
         end
         CFPL_RECOVER:
         begin
            if (st_q.fdr_cnt >= CNT_W'(FDR_CYCLES_P - 1))
            begin
               st_d.state = CFPL_WAIT_OFF;
            end
            else
            begin
               st_d.fdr_cnt = st_q.fdr_cnt + 28'h0000001;
            end
         end
         CFPL_WAIT_OFF:
         begin
            if (off_evt) // RULE14
            begin
               st_d.state     = CFPL_RUN;
               st_d.opp_fault = 1'b0;
               st_d.ocp_fault = 1'b0;
               st_d.scp_fault = 1'b0;
               st_d.test_cnt  = '0;
            end
         end
         default:
         begin
            st_d.state = CFPL_RUN;
         end
      endcase

      st_d.ntc_src = ~st_d.otp_fault; // RULE2
      st_d.clamp   = 1'b1; // RULE10
      // 0.6 V curve top lives in the analog comparator, not here
      st_d.test_ok = (st_d.state == CFPL_RUN); // RULE13
      st_d.stat.recovery_active = (st_d.state != CFPL_RUN); // RULE13
      st_d.stat.gate_inhibit    = (st_d.state != CFPL_RUN) | st_d.otp_fault
                                  | cmp_s.ntc_low & (st_d.test_cnt == TEST_PULSES_MIN);
      st_d.stat.run             = ~st_d.stat.gate_inhibit; // RULE12
      st_d.stat.ntc_ref_high    = st_d.otp_fault; // RULE3
      st_d.stat.otp_fault       = st_d.otp_fault;
      st_d.stat.opp_fault       = st_d.opp_fault;
      st_d.stat.ocp_fault       = st_d.ocp_fault;
      st_d.stat.scp_fault       = st_d.scp_fault;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q          <= '0;
         st_q.state    <= CFPL_RUN;
         st_q.ntc_src  <= 1'b1;
         st_q.clamp    <= 1'b1;
         st_q.test_ok  <= 1'b1;
         st_q.stat.run <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign status             = st_q.stat;
   assign ntc_source_en      = st_q.ntc_src;
   assign peak_current_clamp = st_q.clamp;
   assign test_pulse_allow   = st_q.test_ok;
endmodule

// ==== tb/cfpl_assertions.sv ====
// checker: port-level protection assertions
`timescale 1ns/10ps
module cfpl_assertions
#(
   parameter int unsigned OPP_CYCLES_P = 20,
   parameter int unsigned FDR_CYCLES_P = 50
)
(
   input wire logic                 clk,
   input wire logic                 sys_rst,
   input wire cfpl_pkg::cfpl_cmp_t  cmp_pins,
   input wire logic                 low_side_gate_pulse,
   input wire logic                 supply_turn_off,
   input wire cfpl_pkg::cfpl_stat_t status,
   input wire logic                 ntc_source_en,
   input wire logic                 peak_current_clamp,
   input wire logic                 test_pulse_allow
);
import cfpl_pkg::*;
default clocking cb @(posedge clk); endclocking
default disable iff (sys_rst);
clamp_on_a:
   assert property (peak_current_clamp) else $error("clamp off");
ref_raise_a:
   assert property (status.ntc_ref_high == status.otp_fault) else $error("ref");
source_off_a:
   assert property (ntc_source_en != status.otp_fault) else $error("source");
allow_rec_a:
   assert property (test_pulse_allow != status.recovery_active) else $error("allow");
otp_cause_a:
   assert property ($rose(status.otp_fault) |-> $past(cmp_pins.ntc_low, 6)) else $error("otp");
// the condition must have stood 8 and 16 cycles before the rise, not just at the end
opp_timer_a:
   assert property ($rose(status.opp_fault) |-> $past(cmp_pins.cst_over_opp, 8)
      && $past(cmp_pins.cst_over_opp, 16)) else $error("opp early");
opp_stop_a:
   assert property ($rose(status.opp_fault) |-> status.recovery_active && !status.run
      && status.gate_inhibit) else $error("opp stop");
ocp_stop_a:
   assert property ($rose(status.ocp_fault) |-> !status.run && status.recovery_active) else $error("ocp");
scp_cause_a:
   assert property ($rose(status.scp_fault) |-> status.recovery_active && $past(supply_turn_off, 3))
      else $error("scp");
run_restart_a:
   assert property ($fell(status.recovery_active) |-> $past(supply_turn_off, 3) && !status.opp_fault
      && !status.ocp_fault && !status.scp_fault) else $error("restart");
endmodule
bind cfpl_top cfpl_assertions #(.OPP_CYCLES_P(OPP_CYCLES_P), .FDR_CYCLES_P(FDR_CYCLES_P)) cfpl_assertions_i
   (.clk, .sys_rst, .cmp_pins, .low_side_gate_pulse, .supply_turn_off, .status, .ntc_source_en,
    .peak_current_clamp, .test_pulse_allow);

// ==== tb/cfpl_gate_model.sv ====
// partner: low-side gate pulse source, 4 high 4 low
`timescale 1ns/10ps
module cfpl_gate_model
(
   input  wire logic       clk,
   input  wire logic       en,
   input  wire logic       allow,
   output logic            pulse,
   output logic      [7:0] n_pulses
);
logic [2:0] ph_q = 3'h0;
logic       act;
assign act = (ph_q != 3'h0) || (en && allow);
initial pulse = 1'b0;
initial n_pulses = 8'h0;
// a started pulse always completes, keeping the low gap at four cycles
always @(negedge clk)
begin
   if (act)
      ph_q <= ph_q + 3'h1;
   if (act && ph_q == 3'h0)
      n_pulses <= n_pulses + 8'h1;
   pulse <= act && !ph_q[2];
end
endmodule

// ==== tb/cfpl_top_bench.sv ====
// bench: directed fault-protection sequences
`timescale 1ns/10ps
`define CHK(nm, e, g) \
   begin \
      n_compared++; \
      if ((g) !== (e)) \
      begin \
         fails++; \
         $display("[ERR] %s exp %h got %h", nm, e, g); \
      end \
   end
module cfpl_top_bench;
import cfpl_pkg::*;
localparam int OPC = 20;
localparam int FDC = 50;
logic       clk, sys_rst, lsp, toff, gen, src, clamp, allow;
logic [7:0] np;
cfpl_cmp_t  cmp;
cfpl_stat_t st;
int         fails, n_compared, tmo;
cfpl_top #(.OPP_CYCLES_P(OPC), .FDR_CYCLES_P(FDC)) cfpl_top_i (.clk(clk), .sys_rst(sys_rst),
   .cmp_pins(cmp), .low_side_gate_pulse(lsp), .supply_turn_off(toff), .status(st),
   .ntc_source_en(src), .peak_current_clamp(clamp), .test_pulse_allow(allow));
cfpl_gate_model cfpl_gate_model_i (.clk(clk), .en(gen), .allow(allow), .pulse(lsp), .n_pulses(np));
initial
begin
   clk = 1'b0;
   forever #5 clk = ~clk;
end
task automatic print_verdict();
   $display("compared %0d, failed %0d", n_compared, fails);
   if (fails == 0 && n_compared > 0)
      $display("All tests passed");
   else
      $display("Some tests failed");
   $finish;
endtask
always @(posedge clk)
begin
   tmo++;
   if (tmo == 4000)
   begin
      fails++;
      print_verdict();
   end
end
task automatic cyc(input int n);
   repeat (n) @(negedge clk);
endtask
task automatic pul(input int k);
   logic [7:0] t;
   t = np + 8'(k);
   gen = 1'b1;
   while (np !== t)
      cyc(1);
   gen = 1'b0;
   cyc(12);
endtask
task automatic tof();
   toff = 1'b1;
   cyc(10);
   toff = 1'b0;
   cyc(8);
endtask
initial
begin
   sys_rst = 1'b1;
   toff = 1'b0;
   gen = 1'b0;
   cmp = '0;
   cyc(6);
   sys_rst = 1'b0;
   cyc(1);
   `CHK("status", 8'h40, st)
   `CHK("source", 1'b1, src)
   `CHK("clamp", 1'b1, clamp)
   `CHK("allow", 1'b1, allow)
   // a clean pulse in mid-run restarts the count
   cmp.ntc_low = 1'b1;
   pul(2);
   cmp.ntc_low = 1'b0;
   pul(1);
   cmp.ntc_low = 1'b1;
   pul(3);
   `CHK("otp", 1'b0, st.otp_fault)
   `CHK("inhibit", 1'b1, st.gate_inhibit)
   `CHK("run", 1'b0, st.run)
   pul(1);
   `CHK("otp", 1'b1, st.otp_fault)
   `CHK("ref", 1'b1, st.ntc_ref_high)
   `CHK("source", 1'b0, src)
   cmp.ntc_low = 1'b0;
   pul(1);
   `CHK("otp", 1'b0, st.otp_fault)
   cmp.cs_over_ocp = 1'b1;
   pul(2);
   `CHK("ocp", 1'b0, st.ocp_fault)
   pul(1);
   cmp.cs_over_ocp = 1'b0;
   `CHK("status", 8'h92, st)
   `CHK("allow", 1'b0, allow)
   // turn-off before the long wait ends must not restart
   tof();
   `CHK("ocp", 1'b1, st.ocp_fault)
   cyc(FDC);
   tof();
   `CHK("status", 8'h40, st)
   repeat (2)
   begin
      cmp.cst_over_opp = 1'b1;
      cyc(15);
      cmp.cst_over_opp = 1'b0;
      cyc(6);
   end
   `CHK("opp", 1'b0, st.opp_fault)
   cmp.cst_over_opp = 1'b1;
   cyc(OPC + 8);
   `CHK("status", 8'h94, st)
   cmp.cst_over_opp = 1'b0;
   cyc(FDC);
   tof();
   `CHK("opp", 1'b0, st.opp_fault)
   for (int i = 0; i < 3; i++)
   begin
      cmp.vs_below_short = (i == 0);
      cmp.cst_over_opp = (i == 1);
      tof();
      `CHK("scp", (i < 2), st.scp_fault)
      cmp = '0;
      cyc(FDC);
      tof();
   end
   print_verdict();
end
endmodule
